// >>> aux_pointer_indirect_agen.sv
// indirect operand address generation and update for eight auxiliary pointers
//
// Overview of operation
// - post-add temp_reg_one: address from old pointer, then pointer += signed temp_reg_one.
// - post-subtract temp_reg_one: address from old pointer, then pointer -= temp_reg_one.
// - bit-reversed post-add: reverse-carry add of zero pointer or temp_reg_zero after addressing.
// - bit-reversed post-subtract: reverse-borrow subtract of the same offset after addressing.
// - bit-reversed on circular pointer: buffer start still added, update not wrapped.
// - constant-indexed: address is pointer plus signed 16-bit constant, pointer unchanged.
// - pre-add constant: pointer plus constant becomes both address and new pointer.
// - 16-bit constant comes in extension; never paired with a parallel instruction.
// - post-increment by 1 for single accesses, 2 for double accesses.
// - post-decrement by 1 for single accesses, 2 for double accesses.
// - plain pointer: address is the pointer, pointer unchanged.
// - post-add: add zero pointer if legacy flag set, else temp_reg_zero.
// - post-subtract: subtract zero pointer if legacy flag set, else temp_reg_zero.
// - register-indexed: pointer plus selected signed offset, pointer unchanged.
// - control mode only: pointer plus unsigned 3-bit offset 1..7, unchanged pointer.
// - mode select 0 picks the DSP operand set, 1 the control set.
// - data-space address: 7 high bits from high part, 16 low from pointer.
// - every pointer add or subtract wraps modulo 64K, never into the high part.
// - buffer start added into the address only for circular-enabled pointers.
module aux_pointer_indirect_agen
  import aux_agen_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire aux_agen_pkg::agen_req_t               req,
  input  wire aux_agen_pkg::agen_mode_t              modeCfg,
  input  wire logic [aux_agen_pkg::PTR_W-1:0]        tempRegZero,
  input  wire logic [aux_agen_pkg::PTR_W-1:0]        tempRegOne,
  input  wire logic [aux_agen_pkg::BSA_CNT-1:0][aux_agen_pkg::PTR_W-1:0] bufferStart,
  input  wire logic                                  loadValid,
  input  wire logic [aux_agen_pkg::IDX_W-1:0]        loadIndex,
  input  wire logic [aux_agen_pkg::PTR_W-1:0]        loadLow,
  input  wire logic [aux_agen_pkg::HIGH_W-1:0]       loadHigh,
  output aux_agen_pkg::agen_resp_t                   resp
);
  import aux_agen_pkg::*;

  logic [PTR_CNT-1:0][PTR_W-1:0]  auxPointer;
  logic [PTR_CNT-1:0][HIGH_W-1:0] auxPointerHigh;
  logic [PTR_CNT-1:0][PTR_W-1:0]  next_auxPointer;
  logic [PTR_CNT-1:0][HIGH_W-1:0] next_auxPointerHigh;
  agen_resp_t                     next_resp;

  logic [PTR_W-1:0]  curPointer;
  logic [PTR_W-1:0]  zeroOffset;
  logic [PTR_W-1:0]  step;
  logic [PTR_W-1:0]  brevResult;
  logic [PTR_W-1:0]  basePointer;
  logic [PTR_W-1:0]  updPointer;
  logic [PTR_W-1:0]  circOffset;
  logic [PTR_W-1:0]  effLow;
  logic              legal;
  logic              doUpdate;

  // decides whether an operand exists in the active set and is well formed
  function automatic logic operandLegal(input operand_t op, input logic modeSel,
                                        input logic [2:0] k3, input logic paired);
    logic ok;
    ok = 1'b1;
    case (op)
      OP_PLAIN, OP_POST_INC, OP_POST_DEC, OP_POST_ADD, OP_POST_SUB, OP_IDX_REG: begin
        ok = 1'b1;
      end
      OP_POST_ADD_T1, OP_POST_SUB_T1, OP_BREV_ADD, OP_BREV_SUB: begin
        ok = (modeSel == MODE_DSP);
      end
      OP_IDX_K16, OP_PRE_ADD_K16: begin
        ok = !paired;
      end
      OP_IDX_K3: begin
        ok = (modeSel == MODE_CONTROL) && (k3 >= K3_MIN);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  bit_reverse_adder u_brev (
    .a        (curPointer),
    .b        (zeroOffset),
    .subtract (req.operand == OP_BREV_SUB),
    .sum      (brevResult)
  );

  always_comb begin
    curPointer = auxPointer[req.ptrIndex];
    zeroOffset = modeCfg.legacyCompatFlag ? auxPointer[ZERO_INDEX] : tempRegZero;
    step       = req.wide ? STEP_DOUBLE : STEP_SINGLE;
    legal      = operandLegal(req.operand, modeCfg.pointerModeSelect, req.offsetConst3, req.pairedParallel);
    basePointer = curPointer;
    updPointer  = curPointer;
    doUpdate    = 1'b0;
    // all sums are 16 bits wide so carries fall off at 64K
    case (req.operand)
      OP_PLAIN: begin
        basePointer = curPointer;
      end
      OP_POST_INC: begin
        updPointer = curPointer + step;
        doUpdate   = 1'b1;
      end
      OP_POST_DEC: begin
        updPointer = curPointer - step;
        doUpdate   = 1'b1;
      end
      OP_POST_ADD: begin
        updPointer = curPointer + zeroOffset;
        doUpdate   = 1'b1;
      end
      OP_POST_SUB: begin
        updPointer = curPointer - zeroOffset;
        doUpdate   = 1'b1;
      end
      OP_IDX_REG: begin
        basePointer = curPointer + zeroOffset;
      end
      OP_POST_ADD_T1: begin
        updPointer = curPointer + tempRegOne;
        doUpdate   = 1'b1;
      end
      OP_POST_SUB_T1: begin
        updPointer = curPointer - tempRegOne;
        doUpdate   = 1'b1;
      end
      OP_BREV_ADD, OP_BREV_SUB: begin
        // no circular wrap on the update, only the address sees the buffer start
        updPointer = brevResult;
        doUpdate   = 1'b1;
      end
      OP_IDX_K16: begin
        basePointer = curPointer + req.offsetConst16;
      end
      OP_PRE_ADD_K16: begin
        basePointer = curPointer + req.offsetConst16;
        updPointer  = basePointer;
        doUpdate    = 1'b1;
      end
      OP_IDX_K3: begin
        basePointer = curPointer + {K3_PAD, req.offsetConst3};
      end
      default: begin
        basePointer = curPointer;
      end
    endcase
    circOffset = modeCfg.circularEnable[req.ptrIndex] ? bufferStart[req.ptrIndex[2:1]] : NO_OFFSET;
    effLow     = basePointer + circOffset;
  end

  always_comb begin
    next_auxPointer     = auxPointer;
    next_auxPointerHigh = auxPointerHigh;
    next_resp           = '0;
    next_resp.space     = req.space;
    next_resp.ptrIndex  = req.ptrIndex;
    next_resp.newPointer = curPointer;
    if (req.valid) begin
      next_resp.valid = 1'b1;
      next_resp.error = !legal;
      if (legal) begin
        if ((req.space == SPACE_DATA) || (req.space == SPACE_MMR)) begin
          next_resp.address = {auxPointerHigh[req.ptrIndex], effLow};
        end else begin
          next_resp.address = {HIGH_NONE, effLow};
        end
        if (doUpdate) begin
          next_auxPointer[req.ptrIndex] = updPointer;
          next_resp.newPointer          = updPointer;
        end
      end
    end
    // a software load in the same cycle overrides the hardware update
    if (loadValid) begin
      next_auxPointer[loadIndex]     = loadLow;
      next_auxPointerHigh[loadIndex] = loadHigh;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PTR_CNT; p++) begin
        auxPointer[p]     <= PTR_RESET;
        auxPointerHigh[p] <= HIGH_RESET;
      end
      resp <= '0;
    end else begin
      auxPointer     <= next_auxPointer;
      auxPointerHigh <= next_auxPointerHigh;
      resp           <= next_resp;
    end
  end
endmodule

// >>> aux_agen_pkg.sv
// shared constants, operand codes and carrier structs for the auxiliary pointer address generator
package aux_agen_pkg;

  localparam int PTR_W    = 16;
  localparam int HIGH_W   = 7;
  localparam int ADDR_W   = 23;
  localparam int PTR_CNT  = 8;
  localparam int IDX_W    = 3;
  localparam int BSA_CNT  = 4;

  localparam logic [PTR_W-1:0]  STEP_SINGLE = 16'h0001;
  localparam logic [PTR_W-1:0]  STEP_DOUBLE = 16'h0002;
  localparam logic [PTR_W-1:0]  PTR_RESET   = 16'h0000;
  localparam logic [HIGH_W-1:0] HIGH_RESET  = 7'h00;
  localparam logic [HIGH_W-1:0] HIGH_NONE   = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 23'h000000;
  localparam logic [PTR_W-1:0]  NO_OFFSET   = 16'h0000;
  localparam logic [IDX_W-1:0]  ZERO_INDEX  = 3'h0;
  localparam logic [IDX_W-1:0]  K3_MIN      = 3'h1;
  localparam logic [12:0]       K3_PAD      = 13'h0000;
  localparam logic              MODE_DSP     = 1'b0;
  localparam logic              MODE_CONTROL = 1'b1;

  typedef enum logic [3:0] {
    OP_PLAIN       = 4'h0,
    OP_POST_INC    = 4'h1,
    OP_POST_DEC    = 4'h2,
    OP_POST_ADD    = 4'h3,
    OP_POST_SUB    = 4'h4,
    OP_IDX_REG     = 4'h5,
    OP_POST_ADD_T1 = 4'h6,
    OP_POST_SUB_T1 = 4'h7,
    OP_BREV_ADD    = 4'h8,
    OP_BREV_SUB    = 4'h9,
    OP_IDX_K16     = 4'hA,
    OP_PRE_ADD_K16 = 4'hB,
    OP_IDX_K3      = 4'hC
  } operand_t;

  typedef enum logic [1:0] {
    SPACE_DATA = 2'h0,
    SPACE_MMR  = 2'h1,
    SPACE_BIT  = 2'h2,
    SPACE_IO   = 2'h3
  } space_t;

  typedef struct packed {
    logic              valid;
    operand_t          operand;
    logic [IDX_W-1:0]  ptrIndex;
    space_t            space;
    logic              wide;
    logic              pairedParallel;
    logic [PTR_W-1:0]  offsetConst16;
    logic [2:0]        offsetConst3;
  } agen_req_t;

  typedef struct packed {
    logic              pointerModeSelect;
    logic              legacyCompatFlag;
    logic [PTR_CNT-1:0] circularEnable;
  } agen_mode_t;

  typedef struct packed {
    logic              valid;
    logic              error;
    space_t            space;
    logic [ADDR_W-1:0] address;
    logic [IDX_W-1:0]  ptrIndex;
    logic [PTR_W-1:0]  newPointer;
  } agen_resp_t;

endpackage

// >>> bit_reverse_adder.sv
// 16-bit adder and subtractor with carry or borrow running from msb toward lsb
module bit_reverse_adder (
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic        subtract,
  output logic [15:0]      sum
);
  logic [15:0] aRev;
  logic [15:0] bRev;
  logic [15:0] sumRev;

  // mirroring both operands turns a normal adder into a reverse-carry one
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_mirror
      assign aRev[i] = a[15-i];
      assign bRev[i] = b[15-i];
      assign sum[i]  = sumRev[15-i];
    end
  endgenerate

  always_comb begin
    if (subtract) begin
      sumRev = aRev - bRev;
    end else begin
      sumRev = aRev + bRev;
    end
  end
endmodule

// >>> decoder_model.sv
// decoder-side partner: packs the request and takes the 16-bit constant from its extension
module decoder_model
  import aux_agen_pkg::*;
(
  input  wire aux_agen_pkg::agen_req_t cmd,
  input  wire logic [7:0]              extHi,
  input  wire logic [7:0]              extLo,
  output aux_agen_pkg::agen_req_t      req
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    req = cmd;
    req.offsetConst16 = {extHi, extLo};
  end
endmodule

// >>> aux_agen_asserts.sv
// concurrent checks on the address generator ports
module aux_agen_asserts
  import aux_agen_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire aux_agen_pkg::agen_req_t  req,
  input wire aux_agen_pkg::agen_mode_t modeCfg,
  input wire logic                     loadValid,
  input wire aux_agen_pkg::agen_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take(operand_t o);
    req.valid && req.operand == o && !loadValid && !req.pairedParallel;
  endsequence
  sequence s_then_plain(operand_t o);
    s_take(o) ##1 (s_take(OP_PLAIN) && req.ptrIndex == $past(req.ptrIndex));
  endsequence
  sequence s_refused;
    resp.valid && resp.error && resp.address == 23'h000000;
  endsequence
  a_k16_paired_refused: assert property (req.valid && req.pairedParallel &&
    (req.operand == OP_IDX_K16 || req.operand == OP_PRE_ADD_K16) |=> s_refused) else $error("paired constant taken");
  a_k3_zero_refused: assert property (req.valid && req.operand == OP_IDX_K3 &&
    req.offsetConst3 == 3'h0 |=> s_refused) else $error("zero short offset taken");
  a_k3_ctrl_taken: assert property (s_take(OP_IDX_K3) && req.offsetConst3 != 3'h0 &&
    modeCfg.pointerModeSelect |=> resp.valid && !resp.error) else $error("short offset refused");
  a_k3_dsp_refused: assert property (req.valid && req.operand == OP_IDX_K3 &&
    !modeCfg.pointerModeSelect |=> s_refused) else $error("short offset in dsp set");
  a_t1_ctrl_refused: assert property (req.valid && modeCfg.pointerModeSelect &&
    req.operand inside {OP_POST_ADD_T1, OP_POST_SUB_T1} |=> s_refused) else $error("t1 op in control set");
  a_brev_ctrl_refused: assert property (req.valid && modeCfg.pointerModeSelect &&
    req.operand inside {OP_BREV_ADD, OP_BREV_SUB} |=> s_refused) else $error("bit-reverse in control set");
  a_plain_keeps_ptr: assert property (s_then_plain(OP_PLAIN) |=>
    resp.newPointer == $past(resp.newPointer)) else $error("plain operand moved pointer");
  a_idx_keeps_ptr: assert property (s_then_plain(OP_IDX_K16) |=>
    resp.newPointer == $past(resp.newPointer)) else $error("indexed operand moved pointer");
  a_bitio_no_high: assert property (resp.valid && resp.space inside {SPACE_BIT, SPACE_IO} |->
    resp.address[22:16] == 7'h00) else $error("high part on bit or io access");
endmodule
bind aux_pointer_indirect_agen aux_agen_asserts u_chk (.clk(clk), .rst_n(rst_n), .req(req), .modeCfg(modeCfg),
  .loadValid(loadValid), .resp(resp));

// >>> aux_pointer_indirect_agen_tb_top.sv
// self-checking bench for the auxiliary pointer address generator
module aux_pointer_indirect_agen_tb_top;
  import aux_agen_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        clk, rst_n, loadValid, wd, par, pend, expErr;
  logic [2:0]                  loadIndex, k3;
  logic [15:0]                 tempRegZero, tempRegOne, loadLow, ext, expPtr;
  logic [6:0]                  loadHigh;
  logic [22:0]                 expAddr;
  logic [BSA_CNT-1:0][PTR_W-1:0] bufferStart;
  agen_req_t                   cmd, req;
  agen_mode_t                  modeCfg;
  agen_resp_t                  resp;
  space_t                      sp, expSp;
  logic [2:0]                  expIdx;
  int                          miscompares, cmp_count, cyc;
  decoder_model u_dec (.cmd(cmd), .extHi(ext[15:8]), .extLo(ext[7:0]), .req(req));
  aux_pointer_indirect_agen u_dut (.clk(clk), .rst_n(rst_n), .req(req), .modeCfg(modeCfg),
    .tempRegZero(tempRegZero), .tempRegOne(tempRegOne), .bufferStart(bufferStart), .loadValid(loadValid),
    .loadIndex(loadIndex), .loadLow(loadLow), .loadHigh(loadHigh), .resp(resp));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic ok);
    cmp_count++;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH %0t response differs", $time);
    end
  endtask
  // requests are pipelined: each edge judges the answer to the request set one edge before
  task chk;
    if (pend) cmp(resp.valid === 1'b1 && resp.error === expErr && resp.address === expAddr &&
                  resp.newPointer === expPtr && resp.space === expSp && resp.ptrIndex === expIdx);
    else cmp(resp.valid === 1'b0);
    pend = 1'b0;
  endtask
  task go(input operand_t o, input logic [2:0] i, input logic [15:0] k, input logic [22:0] ea,
          input logic [15:0] ep, input logic ee);
    @(posedge clk);
    cmd <= '{1'b1, o, i, sp, wd, par, 16'h0000, k3};
    ext <= k;
    #1 chk;
    {pend, expAddr, expPtr, expErr} = {1'b1, ea, ep, ee};
    expSp  = sp;
    expIdx = i;
  endtask
  task idle;
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1 chk;
  endtask
  task md(input logic s, input logic l, input logic [7:0] c);
    @(posedge clk);
    cmd.valid <= 1'b0;
    modeCfg <= '{s, l, c};
    #1 chk;
  endtask
  task ld(input logic [2:0] i, input logic [15:0] lo, input logic [6:0] hi);
    @(posedge clk);
    cmd.valid <= 1'b0;
    {loadValid, loadIndex, loadLow, loadHigh} <= {1'b1, i, lo, hi};
    #1 chk;
    @(posedge clk);
    loadValid <= 1'b0;
    #1 chk;
  endtask
  task t_step;
    md(0, 0, 8'h00); ld(2, 16'h0010, 7'h01); ld(3, 16'hFFFF, 7'h05);
    wd = 0; go(OP_POST_INC, 2, 0, 23'h010010, 16'h0011, 0);
    wd = 1; go(OP_POST_INC, 2, 0, 23'h010011, 16'h0013, 0);
    go(OP_POST_DEC, 2, 0, 23'h010013, 16'h0011, 0);
    wd = 0; go(OP_POST_DEC, 2, 0, 23'h010011, 16'h0010, 0);
    go(OP_PLAIN, 2, 0, 23'h010010, 16'h0010, 0);
    go(OP_PLAIN, 2, 0, 23'h010010, 16'h0010, 0);
    go(OP_POST_INC, 3, 0, 23'h05FFFF, 16'h0000, 0);
    go(OP_PLAIN, 3, 0, 23'h050000, 16'h0000, 0);
    idle; $display("test step done");
  endtask
  task t_temp;
    @(posedge clk); tempRegOne <= 16'hFFFE; tempRegZero <= 16'h0005;
    ld(4, 16'h1000, 7'h02); ld(0, 16'h0020, 7'h00);
    go(OP_POST_ADD_T1, 4, 0, 23'h021000, 16'h0FFE, 0);
    go(OP_POST_SUB_T1, 4, 0, 23'h020FFE, 16'h1000, 0);
    md(0, 1, 8'h00);
    go(OP_POST_ADD, 4, 0, 23'h021000, 16'h1020, 0);
    go(OP_IDX_REG, 4, 0, 23'h021040, 16'h1020, 0);
    md(0, 0, 8'h00);
    go(OP_POST_SUB, 4, 0, 23'h021020, 16'h101B, 0);
    go(OP_IDX_REG, 4, 0, 23'h021020, 16'h101B, 0);
    idle; $display("test temp done");
  endtask
  task t_k16;
    ld(5, 16'h8000, 7'h03);
    go(OP_IDX_K16, 5, 16'hFFF0, 23'h037FF0, 16'h8000, 0);
    go(OP_PLAIN, 5, 0, 23'h038000, 16'h8000, 0);
    go(OP_PRE_ADD_K16, 5, 16'h0010, 23'h038010, 16'h8010, 0);
    go(OP_PLAIN, 5, 0, 23'h038010, 16'h8010, 0);
    par = 1; go(OP_PRE_ADD_K16, 5, 16'h0010, 23'h000000, 16'h8010, 1);
    par = 0; idle; $display("test k16 done");
  endtask
  task t_brev;
    @(posedge clk); tempRegZero <= 16'h8000; bufferStart[3] <= 16'h0100;
    md(0, 0, 8'h40); ld(6, 16'h0000, 7'h01); ld(0, 16'h8000, 7'h00); ld(7, 16'h0200, 7'h04);
    go(OP_BREV_ADD, 6, 0, 23'h010100, 16'h8000, 0);
    go(OP_BREV_ADD, 6, 0, 23'h018100, 16'h4000, 0);
    go(OP_BREV_ADD, 6, 0, 23'h014100, 16'hC000, 0);
    md(0, 1, 8'h40);
    go(OP_BREV_SUB, 6, 0, 23'h01C100, 16'h4000, 0);
    go(OP_PLAIN, 7, 0, 23'h040200, 16'h0200, 0);
    sp = SPACE_IO; go(OP_PLAIN, 7, 0, 23'h000200, 16'h0200, 0);
    sp = SPACE_MMR; go(OP_PLAIN, 7, 0, 23'h040200, 16'h0200, 0);
    sp = SPACE_BIT; go(OP_PLAIN, 7, 0, 23'h000200, 16'h0200, 0);
    sp = SPACE_DATA; idle; $display("test brev done");
  endtask
  task t_ctrl;
    md(1, 0, 8'h00);
    k3 = 7; go(OP_IDX_K3, 2, 0, 23'h010017, 16'h0010, 0);
    k3 = 1; go(OP_IDX_K3, 2, 0, 23'h010011, 16'h0010, 0);
    k3 = 0; go(OP_IDX_K3, 2, 0, 23'h000000, 16'h0010, 1);
    go(OP_POST_ADD_T1, 2, 0, 23'h000000, 16'h0010, 1);
    go(OP_BREV_SUB, 2, 0, 23'h000000, 16'h0010, 1);
    go(OP_POST_INC, 2, 0, 23'h010010, 16'h0011, 0);
    md(0, 0, 8'h00);
    k3 = 3; go(OP_IDX_K3, 2, 0, 23'h000000, 16'h0011, 1);
    k3 = 0; idle; $display("test ctrl done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: the whole sequence needs about 70 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    {rst_n, loadValid, wd, par, pend, expErr, loadIndex, k3} = '0;
    {tempRegZero, tempRegOne, loadLow, ext, expPtr, loadHigh, expAddr} = '0;
    {bufferStart, cmd, modeCfg, miscompares, cmp_count, cyc} = '0;
    sp = SPACE_DATA;
    expSp = SPACE_DATA;
    expIdx = 3'h0;
    repeat (3) @(posedge clk);
    #1 cmp(resp === '0);
    @(posedge clk) rst_n <= 1'b1;
    t_step; t_temp; t_k16; t_brev; t_ctrl;
    tally_and_finish;
  end
endmodule
